//--- rtl/fuser_protection_monitor_defs.svh
// Constants for the fuser protection monitor
//
// Overview of operation
// - Primary overheat cuts heater, flags fuser failure
// - Safety path overheat drops triac and relay
// - Triac overcurrent drops triac drive and relay
// - Open thermoswitch drops triac drive and relay
// - Any fuser fault removes all heaters, notifies
// - After init, low temperature flags failure
// - Thermopile drop over window flags failure
// - Slow warm-up after heater on flags failure
// - Out-of-range sensor code flags sensor failure
// - Excess pair difference flags sensor failure
// - Detect fuser presence and voltage variant
// - Fuser ID mismatch with mains flags discrepancy
// - New fuser requests page count clear
// - Relay feedback checked at power-on, sleep exit
// - Mains voltage out of range reports supply fault
// - Overvoltage in sleep reports supply fault
// - Open door holds heaters, HV, motors off
// - Stage setpoint commands applied to heaters
`ifndef FUSER_PROTECTION_MONITOR_DEFS_SVH
`define FUSER_PROTECTION_MONITOR_DEFS_SVH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define REG_CTRL         12'h000
`define REG_SETPOINT     12'h004
`define REG_STATUS       12'h008
`define REG_FAULT        12'h00C
`define REG_TEMP_FUSER   12'h010
`define REG_TEMP_PRESS   12'h014
`define REG_TEMP_IR      12'h018
`define REG_MAINS        12'h01C
`define REG_WINDOW       12'h020

// CTRL bit positions
`define CTRL_HEAT_EN     0
`define CTRL_INIT_DONE   1
`define CTRL_STANDBY     2
`define CTRL_SLEEP       3
`define CTRL_CLEAR       4

// ****************************************************************
// Temperature codes (1 code = 1 C, 9 bits)
// ****************************************************************
`define T_PRI_FUSER      9'd223
`define T_PRI_PRESS      9'd195
`define T_PRI_IR         9'd240
`define T_SAFE_FUSER     9'd230
`define T_SAFE_PRESS     9'd200
`define T_SAFE_IR        9'd250
`define T_LOW_FUSER      9'd120
`define T_LOW_IR         9'd140
`define T_DROP_IR        9'd30
`define T_DIFF_IR        9'd20
`define T_DIFF_FUSER     9'd30
`define T_DIFF_PRESS     9'd25
`define T_CODE_MIN       9'd5
`define T_CODE_MAX       9'd400
`define T_RISE_TARGET    9'd100
`define HYST             9'd5

// Mains frequency limits, Hz
`define F_MIN            8'd40
`define F_MAX            8'd70

// Fault bit positions
`define F_OVERHEAT       0
`define F_SAFETY         1
`define F_OVERCUR        2
`define F_CUTOUT         3
`define F_LOWTEMP        4
`define F_RISE           5
`define F_SENSOR         6
`define F_DRIVE          7
`define F_DISCREP        8
`define F_RELAY          9
`define F_SUPPLY         10
`define F_NUM            11

// Reset values
`define WINDOW_RST       32'h0000_2710
`define RISE_RST         32'h0004_C4B4
`define SETPOINT_RST     27'h0

`endif

//--- rtl/fuser_protection_monitor_pkg.sv
// Types for the fuser protection monitor
package fuser_protection_monitor_pkg;
   typedef logic [8:0] temp_t;
   typedef enum logic [1:0] {FUSER_NONE, FUSER_110, FUSER_220} fuser_kind_e;
endpackage

//--- rtl/fuser_protection_monitor.sv
// Fuser over-temperature protection and fault supervisor
`include "fuser_protection_monitor_defs.svh"

module fuser_protection_monitor
   import fuser_protection_monitor_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Digitised temperatures
   input  wire logic [8:0]  fuser_end_temp_a,
   input  wire logic [8:0]  fuser_end_temp_b,
   input  wire logic [8:0]  pressure_end_temp_a,
   input  wire logic [8:0]  pressure_end_temp_b,
   input  wire logic [8:0]  fuser_center_ir_temp,
   input  wire logic [8:0]  pressure_center_ir_temp,
   // Heater protection inputs
   input  wire logic [2:0]  triacOverCurrent,
   input  wire logic        main_heater_cutout,
   input  wire logic        sub_heater_cutout,
   input  wire logic        pressure_heater_cutout,
   // Supply, identification, doors
   input  wire logic [7:0]  mainsFreqHz,
   input  wire logic        mainsHighVolt,
   input  wire logic        mainsVoltInRange,
   input  wire logic        sleepOverVolt,
   input  wire logic        fuserPresent,
   input  wire logic        fuserIdHighVolt,
   input  wire logic        rightDoorOpen,
   input  wire logic        frontDoorOpen,
   input  wire logic        newFuser,
   input  wire logic        relayFeedback,
   // Heater and power outputs
   output logic             fuser_main_heater,
   output logic             fuser_sub_heater,
   output logic             pressure_heater,
   output logic             triacDriveEn,
   output logic             heaterRelayOn,
   output logic             hvSupplyEn,
   output logic             motorPowerEn,
   // Formatter reports
   output logic             faultNotify,
   output logic             lifeClearReq
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [3:0]        ctrl;
   logic [26:0]       setpoint;
   logic [31:0]       windowCycles;
   logic [31:0]       riseCycles;
   logic [`F_NUM-1:0] faults;
   fuser_kind_e       fuserKind;
   logic [31:0]       winCnt;
   logic [31:0]       riseCnt;
   temp_t             irRefA;
   temp_t             irRefB;
   logic              doorOpenDly;
   logic              sleepDly;
   logic              checkIdPend;
   logic              relayCheckPend;
   logic              newFuserDly;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic absDiffGe(input temp_t a, input temp_t b, input temp_t lim);
      absDiffGe = ((a > b) ? (a - b) : (b - a)) >= lim;
   endfunction

   function automatic logic badCode(input temp_t t);
      badCode = (t < `T_CODE_MIN) || (t > `T_CODE_MAX);
   endfunction

   function automatic logic belowTarget(input temp_t t, input temp_t target);
      belowTarget = t < target;
   endfunction

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire apbAccess = psel && penable;
   wire apbWrite  = apbAccess && pwrite;
   wire apbRead   = apbAccess && !pwrite;
   wire mapped    = (paddr[1:0] == 2'b00) && (paddr <= `REG_WINDOW);
   wire wrCtrl    = apbWrite && (paddr == `REG_CTRL);
   wire wrSetp    = apbWrite && (paddr == `REG_SETPOINT);
   wire wrWindow  = apbWrite && (paddr == `REG_WINDOW);
   wire wrRise    = apbWrite && (paddr == `REG_MAINS);
   wire clearReq  = wrCtrl && pwdata[`CTRL_CLEAR];

   wire heatEn    = ctrl[`CTRL_HEAT_EN];
   wire initDone  = ctrl[`CTRL_INIT_DONE];
   wire standby   = ctrl[`CTRL_STANDBY];
   wire sleepMode = ctrl[`CTRL_SLEEP];
   wire doorOpen  = rightDoorOpen || frontDoorOpen;

   // ****************************************************************
   // Fault conditions
   // ****************************************************************
   wire overPrimary =
      (fuser_end_temp_a >= `T_PRI_FUSER) || (fuser_end_temp_b >= `T_PRI_FUSER) ||
      (pressure_end_temp_a >= `T_PRI_PRESS) || (pressure_end_temp_b >= `T_PRI_PRESS) ||
      (fuser_center_ir_temp >= `T_PRI_IR) || (pressure_center_ir_temp >= `T_PRI_IR);
   wire overSafety =
      (fuser_end_temp_a >= `T_SAFE_FUSER) || (fuser_end_temp_b >= `T_SAFE_FUSER) ||
      (pressure_end_temp_a >= `T_SAFE_PRESS) || (pressure_end_temp_b >= `T_SAFE_PRESS) ||
      (fuser_center_ir_temp >= `T_SAFE_IR) || (pressure_center_ir_temp >= `T_SAFE_IR);
   wire overCurrent = |triacOverCurrent;
   wire cutoutOpen  = main_heater_cutout || sub_heater_cutout ||
                      pressure_heater_cutout;
   wire lowStatic   = initDone && (
      (fuser_end_temp_a <= `T_LOW_FUSER) || (fuser_end_temp_b <= `T_LOW_FUSER) ||
      (fuser_center_ir_temp <= `T_LOW_IR) || (pressure_center_ir_temp <= `T_LOW_IR));
   wire dropA = (irRefA > fuser_center_ir_temp) &&
                ((irRefA - fuser_center_ir_temp) >= `T_DROP_IR);
   wire dropB = (irRefB > pressure_center_ir_temp) &&
                ((irRefB - pressure_center_ir_temp) >= `T_DROP_IR);
   wire lowDrop     = initDone && (dropA || dropB);
   wire notWarm     = belowTarget(fuser_end_temp_a, `T_RISE_TARGET) ||
                      belowTarget(fuser_center_ir_temp, `T_RISE_TARGET);
   wire riseFail    = heatEn && notWarm && (riseCnt >= riseCycles);
   wire sensorBad   =
      badCode(fuser_end_temp_a) || badCode(fuser_end_temp_b) ||
      badCode(pressure_end_temp_a) || badCode(pressure_end_temp_b) ||
      badCode(fuser_center_ir_temp) || badCode(pressure_center_ir_temp) ||
      absDiffGe(fuser_center_ir_temp, pressure_center_ir_temp, `T_DIFF_IR) ||
      absDiffGe(fuser_end_temp_a, fuser_end_temp_b, `T_DIFF_FUSER) ||
      absDiffGe(pressure_end_temp_a, pressure_end_temp_b, `T_DIFF_PRESS);
   wire driveFail   = (!initDone || standby) &&
                      ((mainsFreqHz < `F_MIN) || (mainsFreqHz > `F_MAX));
   wire idMismatch  = checkIdPend && fuserPresent &&
                      (fuserIdHighVolt != mainsHighVolt);
   wire relayFail   = relayCheckPend && relayFeedback;
   wire supplyFail  = !mainsVoltInRange ||
                      (sleepMode && sleepOverVolt);

   wire [`F_NUM-1:0] events = {supplyFail, relayFail, idMismatch, driveFail,
                               sensorBad, riseFail, lowStatic | lowDrop,
                               cutoutOpen, overCurrent, overSafety, overPrimary};

   // Set beats clear; latched until reset or formatter clear
   wire [`F_NUM-1:0] next_faults = (clearReq ? '0 : faults) | events;

   wire anyFault     = |next_faults;
   wire hardTrip     = next_faults[`F_SAFETY] | next_faults[`F_OVERCUR] |
                       next_faults[`F_CUTOUT];
   wire doorClosed   = doorOpenDly && !rightDoorOpen;
   wire sleepExit    = sleepDly && !sleepMode;

   // ****************************************************************
   // Read mux
   // ****************************************************************
   wire [31:0] rdMux =
      (paddr == `REG_CTRL)       ? {28'h0, ctrl} :
      (paddr == `REG_SETPOINT)   ? {5'h0, setpoint} :
      (paddr == `REG_STATUS)     ? {26'h0, fuserKind, heaterRelayOn, triacDriveEn,
                                    lifeClearReq, faultNotify} :
      (paddr == `REG_FAULT)      ? {21'h0, faults} :
      (paddr == `REG_TEMP_FUSER) ? {7'h0, fuser_end_temp_b, 7'h0, fuser_end_temp_a} :
      (paddr == `REG_TEMP_PRESS) ? {7'h0, pressure_end_temp_b, 7'h0, pressure_end_temp_a} :
      (paddr == `REG_TEMP_IR)    ? {7'h0, pressure_center_ir_temp, 7'h0,
                                    fuser_center_ir_temp} :
      (paddr == `REG_MAINS)      ? riseCycles :
                                   windowCycles;

   // ****************************************************************
   // APB and control registers
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl         <= 4'h0;
         setpoint     <= `SETPOINT_RST;
         windowCycles <= `WINDOW_RST;
         riseCycles   <= `RISE_RST;
         prdata       <= 32'h0;
         pready       <= 1'b0;
         pslverr      <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= (psel && !penable && !pwrite && mapped) ? rdMux : 32'h0;
         if (wrCtrl)
            ctrl <= pwdata[3:0];
         if (wrSetp)
            setpoint <= pwdata[26:0];
         if (wrWindow)
            windowCycles <= pwdata;
         if (wrRise)
            riseCycles <= pwdata;
      end
   end

   // ****************************************************************
   // Timers and reference samples
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         winCnt  <= 32'h0;
         riseCnt <= 32'h0;
         irRefA  <= 9'h0;
         irRefB  <= 9'h0;
      end else begin
         if (winCnt >= windowCycles || !initDone) begin
            winCnt <= 32'h0;
            irRefA <= fuser_center_ir_temp;
            irRefB <= pressure_center_ir_temp;
         end else begin
            winCnt <= winCnt + 32'h1;
         end
         if (!heatEn || !notWarm)
            riseCnt <= 32'h0;
         else if (riseCnt < riseCycles)
            riseCnt <= riseCnt + 32'h1;
      end
   end

   // ****************************************************************
   // Fault latch, identification, event checks
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         faults         <= '0;
         fuserKind      <= FUSER_NONE;
         doorOpenDly    <= 1'b0;
         sleepDly       <= 1'b0;
         checkIdPend    <= 1'b1;
         relayCheckPend <= 1'b1;
         newFuserDly    <= 1'b0;
         lifeClearReq   <= 1'b0;
         faultNotify    <= 1'b0;
      end else begin
         faults      <= next_faults;
         faultNotify <= anyFault;
         doorOpenDly <= rightDoorOpen;
         sleepDly    <= sleepMode;
         newFuserDly <= newFuser;
         lifeClearReq <= newFuser && !newFuserDly;
         checkIdPend    <= doorClosed;
         relayCheckPend <= sleepExit;
         if (checkIdPend)
            fuserKind <= !fuserPresent ? FUSER_NONE :
                         (fuserIdHighVolt ? FUSER_220 : FUSER_110);
      end
   end

   // ****************************************************************
   // Heater and power drive
   // ****************************************************************
   wire allowHeat = heatEn && !anyFault && !doorOpen;
   wire [8:0] spMain = setpoint[8:0];
   wire [8:0] spSub  = setpoint[17:9];
   wire [8:0] spPres = setpoint[26:18];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fuser_main_heater <= 1'b0;
         fuser_sub_heater  <= 1'b0;
         pressure_heater   <= 1'b0;
         triacDriveEn      <= 1'b0;
         heaterRelayOn     <= 1'b0;
         hvSupplyEn        <= 1'b0;
         motorPowerEn      <= 1'b0;
      end else begin
         // Stage setpoints with small hysteresis band
         if (!allowHeat)
            fuser_main_heater <= 1'b0;
         else if (fuser_center_ir_temp < spMain - `HYST)
            fuser_main_heater <= 1'b1;
         else if (fuser_center_ir_temp >= spMain)
            fuser_main_heater <= 1'b0;
         if (!allowHeat)
            fuser_sub_heater <= 1'b0;
         else if (fuser_end_temp_a < spSub - `HYST)
            fuser_sub_heater <= 1'b1;
         else if (fuser_end_temp_a >= spSub)
            fuser_sub_heater <= 1'b0;
         if (!allowHeat)
            pressure_heater <= 1'b0;
         else if (pressure_center_ir_temp < spPres - `HYST)
            pressure_heater <= 1'b1;
         else if (pressure_center_ir_temp >= spPres)
            pressure_heater <= 1'b0;
         triacDriveEn  <= !hardTrip && !doorOpen && heatEn;
         heaterRelayOn <= !hardTrip && !doorOpen && !sleepMode;
         hvSupplyEn    <= !doorOpen && !sleepMode;
         motorPowerEn  <= !doorOpen && !sleepMode;
      end
   end

endmodule // fuser_protection_monitor

//--- test/fuser_protection_monitor_assertions.sv
// Port-level assertions for the fuser protection monitor
module fuser_protection_monitor_checker (
   // Clock, reset and bus
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // Sensed inputs
   input wire logic [8:0]  fuser_end_temp_a,
   input wire logic [8:0]  pressure_end_temp_a,
   input wire logic [8:0]  fuser_center_ir_temp,
   input wire logic [2:0]  triacOverCurrent,
   input wire logic        main_heater_cutout,
   input wire logic        sub_heater_cutout,
   input wire logic        pressure_heater_cutout,
   input wire logic        mainsVoltInRange,
   input wire logic        frontDoorOpen,
   input wire logic        rightDoorOpen,
   input wire logic        newFuser,
   // Outputs
   input wire logic        fuser_main_heater,
   input wire logic        fuser_sub_heater,
   input wire logic        pressure_heater,
   input wire logic        triacDriveEn,
   input wire logic        heaterRelayOn,
   input wire logic        hvSupplyEn,
   input wire logic        motorPowerEn,
   input wire logic        faultNotify,
   input wire logic        lifeClearReq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Helpers and properties
   // ****************************************************************
   logic clrSeen;
   wire  heatAny  = fuser_main_heater | fuser_sub_heater | pressure_heater;
   wire  clrWrite = psel & penable & pwrite & pready & (paddr == 12'h000) & pwdata[4];
   wire  cutAny   = main_heater_cutout | sub_heater_cutout | pressure_heater_cutout;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         clrSeen <= 1'b0;
      else
         clrSeen <= clrWrite;
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   primary_trip_a: assert property ((fuser_end_temp_a >= 9'h0DF || pressure_end_temp_a >= 9'h0C3
      || fuser_center_ir_temp >= 9'h0F0) |=> faultNotify && !heatAny) else $error("primary trip");
   safety_trip_a: assert property ((fuser_end_temp_a >= 9'h0E6 || pressure_end_temp_a >= 9'h0C8
      || fuser_center_ir_temp >= 9'h0FA) |=> !triacDriveEn && !heaterRelayOn) else $error("safety trip");
   overcurrent_trip_a: assert property (|triacOverCurrent |=> !triacDriveEn && !heaterRelayOn)
      else $error("overcurrent trip");
   cutout_trip_a: assert property (cutAny |=> !triacDriveEn && !heaterRelayOn)
      else $error("cutout trip");
   fault_heat_off_a: assert property (faultNotify |-> !heatAny) else $error("heater on in fault");
   code_range_a: assert property ((pressure_end_temp_a < 9'h005 || fuser_end_temp_a > 9'h190)
      |=> faultNotify) else $error("bad code not flagged");
   supply_fault_a: assert property (!mainsVoltInRange |=> faultNotify) else $error("supply fault");
   door_hold_a: assert property ((frontDoorOpen || rightDoorOpen)
      |=> !hvSupplyEn && !motorPowerEn && !heatAny) else $error("power on with door open");
   life_pulse_a: assert property ($rose(newFuser) |=> lifeClearReq ##1 !lifeClearReq)
      else $error("life clear pulse");
   fault_latch_a: assert property ($fell(faultNotify) |-> clrSeen || $past(clrSeen))
      else $error("fault dropped without clear");
   apb_answer_a: assert property (psel && !penable |=> pready && penable) else $error("apb answer");

   cover property (faultNotify ##1 !faultNotify);
   cover property (lifeClearReq);
   cover property (|triacOverCurrent ##1 !heaterRelayOn);
endmodule // fuser_protection_monitor_checker

//--- test/formatter_model.sv
// Formatter-side model: fuser page count and life requests
module formatter_model #(
   parameter int WARN_COUNT = 4,
   parameter int MAX_COUNT  = 6
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Page events and monitor reports
   input  wire logic        pageDone,
   input  wire logic        lifeClearReq,
   input  wire logic        faultNotify,
   // Life status
   output logic      [15:0] pageCount,
   output logic             orderWarn,
   output logic             replacePrompt
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         pageCount <= 16'h0000;
      else if (lifeClearReq)
         pageCount <= 16'h0000;
      else if (pageDone && !faultNotify)
         pageCount <= pageCount + 16'h0001;
   end

   assign orderWarn     = pageCount >= 16'(WARN_COUNT);
   assign replacePrompt = pageCount >= 16'(MAX_COUNT);
endmodule // formatter_model

//--- test/fuser_protection_monitor_bench.sv
// Testbench for the fuser protection monitor
module fuser_protection_monitor_bench
   import fuser_protection_monitor_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Signals, tasks and sequence
   // ****************************************************************
   logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, rdErr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdData;
   temp_t       fuser_end_temp_a, fuser_end_temp_b, pressure_end_temp_a, pressure_end_temp_b;
   temp_t       fuser_center_ir_temp, pressure_center_ir_temp, fe, pa, ir;
   logic [2:0]  triacOverCurrent;
   logic [7:0]  mainsFreqHz;
   logic        main_heater_cutout, sub_heater_cutout, pressure_heater_cutout, mainsHighVolt;
   logic        mainsVoltInRange, sleepOverVolt, fuserPresent, fuserIdHighVolt, rightDoorOpen;
   logic        frontDoorOpen, newFuser, relayFeedback, fuser_main_heater, fuser_sub_heater;
   logic        pressure_heater, triacDriveEn, heaterRelayOn, hvSupplyEn, motorPowerEn;
   logic        faultNotify, lifeClearReq, pageDone, orderWarn, replacePrompt;
   logic [15:0] pageCount;
   int          num_errors, total_checks;
   logic [3:0]  ctrlTab [14] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h0,
                                  4'h1, 4'h2, 4'h2, 4'hA};
   logic [11:0] maskTab [14] = '{12'h001, 12'h001, 12'h011, 12'h002, 12'h004, 12'h008, 12'h010,
                                  12'h040, 12'h040, 12'h080, 12'h020, 12'h400, 12'h100, 12'h600};

   fuser_protection_monitor u_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .fuser_end_temp_a, .fuser_end_temp_b, .pressure_end_temp_a,
      .pressure_end_temp_b, .fuser_center_ir_temp, .pressure_center_ir_temp, .triacOverCurrent,
      .main_heater_cutout, .sub_heater_cutout, .pressure_heater_cutout, .mainsFreqHz,
      .mainsHighVolt, .mainsVoltInRange, .sleepOverVolt, .fuserPresent, .fuserIdHighVolt,
      .rightDoorOpen, .frontDoorOpen, .newFuser, .relayFeedback, .fuser_main_heater,
      .fuser_sub_heater, .pressure_heater, .triacDriveEn, .heaterRelayOn, .hvSupplyEn,
      .motorPowerEn, .faultNotify, .lifeClearReq);
   formatter_model u_fmt (.sys_clk, .rst_n, .pageDone, .lifeClearReq, .faultNotify, .pageCount,
      .orderWarn, .replacePrompt);

   always #50 sys_clk = ~sys_clk;

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1)
            break;
      end
      if (n == 20) begin
         num_errors++;
         test_done();
      end
      rdData = prdata;
      rdErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Case index selects the abnormal inputs of one fault case, -1 gives nominal values
   task automatic drive(input int i);
      fe = i == 0 ? 9'h0DF : i == 3 ? 9'h0E6 : i == 6 ? 9'h078 : i == 10 ? 9'h05A : 9'h0B4;
      pa = i == 1 ? 9'h0C3 : i == 7 ? 9'h003 : 9'h0AA;
      ir = i == 2 ? 9'h0F0 : i == 10 ? 9'h05A : 9'h0BE;
      fuser_end_temp_a        <= fe;
      fuser_end_temp_b        <= fe + 9'(fe == 9'h0B4);
      pressure_end_temp_a     <= pa;
      pressure_end_temp_b     <= i == 8 ? 9'h091 : pa;
      fuser_center_ir_temp    <= ir;
      pressure_center_ir_temp <= ir;
      triacOverCurrent        <= i == 4 ? 3'h4 : 3'h0;
      main_heater_cutout      <= i == 5;
      sub_heater_cutout       <= i == 5;
      pressure_heater_cutout  <= i == 5;
      mainsFreqHz             <= i == 9 ? 8'h47 : 8'h32;
      mainsVoltInRange        <= i != 11;
      fuserIdHighVolt         <= i != 12;
      relayFeedback           <= i == 13;
      sleepOverVolt           <= i == 13;
   endtask

   task automatic doorPulse();
      rightDoorOpen <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rightDoorOpen <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask

   initial begin
      {sys_clk, rst_n, psel, penable, pwrite, paddr, pwdata, pageDone} = '0;
      {frontDoorOpen, rightDoorOpen, newFuser} = '0;
      {mainsHighVolt, fuserPresent} = 2'h3;
      drive(-1);
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      xfer(1'b0, 12'h020, 32'h0);
      chk("window reset", 32'h00002710, rdData);
      xfer(1'b0, 12'h01C, 32'h0);
      chk("rise reset", 32'h0004C4B4, rdData);
      xfer(1'b0, 12'h00C, 32'h0);
      chk("faults at start", 32'h0, rdData);
      xfer(1'b0, 12'h008, 32'h0);
      chk("fuser kind", 32'h28, rdData);
      xfer(1'b0, 12'h040, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, rdErr});
      chk("unmapped data", 32'h0, rdData);
      xfer(1'b1, 12'h01C, 32'h14);
      xfer(1'b1, 12'h020, 32'h14);
      xfer(1'b1, 12'h004, 32'hFFFFFFFF);
      xfer(1'b0, 12'h004, 32'h0);
      chk("setpoint", 32'h07FFFFFF, rdData);
      for (int i = 0; i < 14; i++) begin
         xfer(1'b1, 12'h000, {28'h0, ctrlTab[i]});
         drive(i);
         if (i == 12)
            doorPulse();
         if (i == 13)
            xfer(1'b1, 12'h000, 32'h2);
         repeat (40) @(posedge sys_clk);
         drive(-1);
         repeat (40) @(posedge sys_clk);
         xfer(1'b0, 12'h00C, 32'h0);
         chk("fault bits", {20'h0, maskTab[i]}, rdData & {20'h0, maskTab[i]});
         @(negedge sys_clk);
         chk("notify", 32'h1, {31'h0, faultNotify});
         xfer(1'b1, 12'h000, 32'h12);
         xfer(1'b0, 12'h00C, 32'h0);
         chk("fault cleared", 32'h0, rdData);
      end
      mainsHighVolt   <= 1'b0;
      fuserIdHighVolt <= 1'b0;
      doorPulse();
      xfer(1'b0, 12'h008, 32'h0);
      chk("kind low volt", 32'h18, rdData);
      xfer(1'b0, 12'h00C, 32'h0);
      chk("matched id", 32'h0, rdData);
      fuserPresent <= 1'b0;
      doorPulse();
      xfer(1'b0, 12'h008, 32'h0);
      chk("kind absent", 32'h08, rdData);
      fuserPresent  <= 1'b1;
      mainsHighVolt <= 1'b1;
      drive(-1);
      doorPulse();
      xfer(1'b1, 12'h000, 32'h12);
      frontDoorOpen <= 1'b1;
      repeat (3) @(posedge sys_clk);
      frontDoorOpen <= 1'b0;
      @(negedge sys_clk);
      chk("hv and motors", 32'h0, {30'h0, hvSupplyEn, motorPowerEn});
      for (int k = 0; k < 5; k++) begin
         @(posedge sys_clk);
         pageDone <= 1'b1;
         @(posedge sys_clk);
         pageDone <= 1'b0;
      end
      newFuser <= 1'b1;
      @(negedge sys_clk);
      chk("pages", 32'h20005, {14'h0, orderWarn, replacePrompt, pageCount});
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("new fuser", 32'h30000, {14'h0, hvSupplyEn, motorPowerEn, pageCount});
      test_done();
   end
endmodule // fuser_protection_monitor_bench

bind fuser_protection_monitor fuser_protection_monitor_checker u_chk (.sys_clk, .rst_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .fuser_end_temp_a, .pressure_end_temp_a,
   .fuser_center_ir_temp, .triacOverCurrent, .main_heater_cutout, .sub_heater_cutout,
   .pressure_heater_cutout, .mainsVoltInRange, .frontDoorOpen, .rightDoorOpen, .newFuser,
   .fuser_main_heater, .fuser_sub_heater, .pressure_heater, .triacDriveEn, .heaterRelayOn,
   .hvSupplyEn, .motorPowerEn, .faultNotify, .lifeClearReq);
